// *** verilog/sndgen_top.sv ***
`timescale 1ns/10ps
`include "sndgen_defines.svh"
// What this block does
// - amplitude period lasts period field plus one ticks
// - amplitude high lasts high field plus one ticks
// - tone period is twice period plus two
// - tone high lasts high field plus one
// - time period is duration period plus one tones
// - segment ends after count plus one time periods
// - separate or combined output format
// - ramp setting keeps volume constant or decreasing
// - segment end copies buffered into current gaplessly
// - segment end pulses trigger, sets complete cause
// - no buffered structure: underflow, sound stops
// - complete cause set when segment finishes
// - underflow cause set when structure missing
// - interface underflow when sample pair late
// - selectable interface clock source, divided and gated into the pwm tick; master_clock_out is undivided and ungated
// - pwm clock times both outputs

module sndgen_top
  import sndgen_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // clock pins
  input wire logic [3:0] system_clock_inputs,
  input wire logic master_clock_in,
  output logic master_clock_out,
  // sound outputs and events
  output logic volume_pwm_out,
  output logic pitch_pwm_out,
  output logic segment_done_trigger,
  output logic irq
);

  typedef struct packed {
    sndgen_state_t st;
    logic en;
    logic comb;
    logic [2:0] if_sel;
    logic [7:0] if_div;
    logic [15:0] b_aper, b_ahigh, b_tper, b_thigh, b_dper, b_nr;
    logic b_ramp;
    logic buf_valid;
    logic [15:0] c_aper, c_ahigh, c_tper, c_thigh, c_dper, c_nr;
    logic c_ramp;
    logic [15:0] ampl_cnt;
    logic [16:0] tone_cnt;
    logic [15:0] time_cnt;
    logic [15:0] nr_cnt;
    logic [2:0] intr;
    logic [2:0] mask;
    logic irq;
    logic trig;
    logic vol_out;
    logic pitch_out;
    logic aw_got, w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } sndgen_state_s_t;

  sndgen_state_s_t q;
  sndgen_state_s_t n;
  logic tick;
  logic mck_lvl;
  logic ampl_end, tone_end, time_end, nr_end, seg_end;
  logic [2:0] intr_set, intr_clr;
  logic bufv_set, bufv_use;
  logic [31:0] rd_word;
  logic rd_ok;

  function automatic logic [31:0] sndgen_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : sndgen_merge

  // ----------------------------------------------------------------------
  // interface clock: select; divide and gate for the pwm tick only
  // ----------------------------------------------------------------------
  sndgen_clkdiv i_sndgen_clkdiv (
    .aclk(aclk),
    .aresetn(aresetn),
    .system_clock_inputs(system_clock_inputs),
    .master_clock_in(master_clock_in),
    .sel(q.if_sel),
    .div(q.if_div),
    .gate_en(q.en),
    .tick(tick),
    .clk_level(mck_lvl)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    logic a_hi, t_hi;
    wv = 32'h0000_0000;
    a_hi = 1'b0;
    t_hi = 1'b0;
    n = q;
    intr_set = 3'h0;
    intr_clr = 3'h0;
    bufv_set = 1'b0;
    bufv_use = 1'b0;
    n.trig = 1'b0;

    // read decode
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      `SNDGEN_ADDR_CTRL: rd_word = {30'h0, q.comb, q.en};
      `SNDGEN_ADDR_IFCLK: rd_word = {16'h0, q.if_div, 5'h0, q.if_sel};
      `SNDGEN_ADDR_VOLUME: rd_word = {q.b_ahigh, q.b_aper};
      `SNDGEN_ADDR_PITCH: rd_word = {q.b_thigh, q.b_tper};
      `SNDGEN_ADDR_DURATION: rd_word = {q.b_nr, q.b_dper};
      `SNDGEN_ADDR_RAMP: rd_word = {31'h0, q.b_ramp};
      `SNDGEN_ADDR_STATUS:
        rd_word = {30'h0, q.buf_valid, q.st == SNDGEN_PLAY};
      `SNDGEN_ADDR_INTR: rd_word = {29'h0, q.intr};
      `SNDGEN_ADDR_INTR_MASK: rd_word = {29'h0, q.mask};
      `SNDGEN_ADDR_INTR_MASKED: rd_word = {29'h0, q.intr & q.mask};
      default: begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase

    // axi write: address and data taken in either order
    if (s_axi_awvalid && q.awready) begin
      n.aw_got = 1'b1;
      n.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `SNDGEN_RESP_OKAY;
      unique case (q.waddr)
        `SNDGEN_ADDR_CTRL: begin
          wv = sndgen_merge({30'h0, q.comb, q.en}, q.wdata, q.wstrb);
          n.en = wv[`SNDGEN_CTRL_EN];
          n.comb = wv[`SNDGEN_CTRL_COMB];
        end
        `SNDGEN_ADDR_IFCLK: begin
          wv = sndgen_merge({16'h0, q.if_div, 5'h0, q.if_sel}, q.wdata,
            q.wstrb);
          n.if_sel = wv[`SNDGEN_IF_SEL_LSB +: 3];
          n.if_div = wv[`SNDGEN_IF_DIV_LSB +: 8];
        end
        `SNDGEN_ADDR_VOLUME: begin
          wv = sndgen_merge({q.b_ahigh, q.b_aper}, q.wdata, q.wstrb);
          {n.b_ahigh, n.b_aper} = wv;
        end
        `SNDGEN_ADDR_PITCH: begin
          wv = sndgen_merge({q.b_thigh, q.b_tper}, q.wdata, q.wstrb);
          {n.b_thigh, n.b_tper} = wv;
        end
        `SNDGEN_ADDR_DURATION: begin
          wv = sndgen_merge({q.b_nr, q.b_dper}, q.wdata, q.wstrb);
          {n.b_nr, n.b_dper} = wv;
        end
        `SNDGEN_ADDR_RAMP: begin
          wv = sndgen_merge({31'h0, q.b_ramp}, q.wdata, q.wstrb);
          n.b_ramp = wv[0];
        end
        `SNDGEN_ADDR_STATUS: begin
          wv = sndgen_merge(32'h0, q.wdata, q.wstrb);
          bufv_set = wv[`SNDGEN_STAT_BUFV];
        end
        `SNDGEN_ADDR_INTR: begin
          wv = sndgen_merge(32'h0, q.wdata, q.wstrb);
          intr_clr = wv[2:0];
        end
        `SNDGEN_ADDR_INTR_MASK: begin
          wv = sndgen_merge({29'h0, q.mask}, q.wdata, q.wstrb);
          n.mask = wv[2:0];
        end
        `SNDGEN_ADDR_INTR_MASKED: ;
        default: n.bresp = `SNDGEN_RESP_SLVERR;
      endcase
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;

    // axi read
    if (s_axi_rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rdata = rd_word;
      n.rresp = rd_ok ? `SNDGEN_RESP_OKAY : `SNDGEN_RESP_SLVERR;
    end
    n.arready = !n.rvalid && !(s_axi_arvalid && q.arready);

    // segment timing, advanced only on pwm clock ticks
    ampl_end = q.ampl_cnt == q.c_aper;
    tone_end = q.tone_cnt == {q.c_tper, 1'b1};
    time_end = q.time_cnt == q.c_dper;
    nr_end = q.nr_cnt == q.c_nr;
    seg_end = (q.st == SNDGEN_PLAY) && tick && ampl_end && tone_end &&
      time_end && nr_end;

    unique case (q.st)
      SNDGEN_IDLE: begin
        if (q.en && q.buf_valid) begin
          n.st = SNDGEN_LOAD;
        end
      end
      SNDGEN_LOAD: begin
        // no sample pair exists yet, a tick here is missed
        if (tick) begin
          intr_set[`SNDGEN_INTR_IF_UNDERFLOW] = 1'b1;
        end
        n.st = SNDGEN_PLAY;
      end
      SNDGEN_PLAY: begin
        if (tick) begin
          n.ampl_cnt = ampl_end ? 16'h0000 : q.ampl_cnt + 16'h0001;
          if (ampl_end) begin
            n.tone_cnt = tone_end ? 17'h00000 : q.tone_cnt + 17'h00001;
          end
          if (ampl_end && tone_end) begin
            n.time_cnt = time_end ? 16'h0000 : q.time_cnt + 16'h0001;
            // decreasing volume: shorten high time per time period
            if (time_end && q.c_ramp && q.c_ahigh != 16'h0000) begin
              n.c_ahigh = q.c_ahigh - 16'h0001;
            end
          end
          if (ampl_end && tone_end && time_end) begin
            n.nr_cnt = nr_end ? 16'h0000 : q.nr_cnt + 16'h0001;
          end
        end
        if (seg_end) begin
          n.trig = 1'b1;
          intr_set[`SNDGEN_INTR_COMPLETE] = 1'b1;
          if (!q.buf_valid) begin
            intr_set[`SNDGEN_INTR_UNDERFLOW] = 1'b1;
            n.st = SNDGEN_IDLE;
          end
        end
        if (!q.en) begin
          n.st = SNDGEN_IDLE;
        end
      end
      default: n.st = SNDGEN_IDLE;
    endcase

    // take over the buffered structure at start or at segment end
    if ((q.st == SNDGEN_IDLE && q.en && q.buf_valid) ||
        (seg_end && q.buf_valid && q.en)) begin
      bufv_use = 1'b1;
      n.c_aper = q.b_aper;
      n.c_ahigh = q.b_ahigh;
      n.c_tper = q.b_tper;
      n.c_thigh = q.b_thigh;
      n.c_dper = q.b_dper;
      n.c_nr = q.b_nr;
      n.c_ramp = q.b_ramp;
    end
    if (n.st != SNDGEN_PLAY || bufv_use) begin
      n.ampl_cnt = 16'h0000;
      n.tone_cnt = 17'h00000;
      n.time_cnt = 16'h0000;
      n.nr_cnt = 16'h0000;
    end
    // a commit landing with the take-over keeps the new structure
    n.buf_valid = (q.buf_valid && !bufv_use) || bufv_set;

    // outputs from the coming counter values
    a_hi = n.ampl_cnt <= n.c_ahigh;
    t_hi = n.tone_cnt <= {1'b0, n.c_thigh};
    if (n.st == SNDGEN_PLAY) begin
      n.vol_out = n.comb ? (a_hi && t_hi) : a_hi;
      n.pitch_out = !n.comb && t_hi;
    end else begin
      n.vol_out = 1'b0;
      n.pitch_out = 1'b0;
    end

    // set wins over a clear in the same cycle
    n.intr = (q.intr & ~intr_clr) | intr_set;
    n.irq = |(n.intr & n.mask);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= SNDGEN_IDLE;
      q.if_sel <= `SNDGEN_RST_SEL;
      q.if_div <= `SNDGEN_RST_DIV;
      q.mask <= `SNDGEN_RST_MASK;
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign master_clock_out = mck_lvl;
  assign volume_pwm_out = q.vol_out;
  assign pitch_pwm_out = q.pitch_out;
  assign segment_done_trigger = q.trig;
  assign irq = q.irq;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_seg_end;
    seg_end && q.en;
  endsequence
  sequence s_done;
    segment_done_trigger && q.intr[`SNDGEN_INTR_COMPLETE];
  endsequence

  AST_AMPL_WRAP: assert property (
    (q.st == SNDGEN_PLAY) && tick && ampl_end |=> q.ampl_cnt == 16'h0000)
    else $error("amplitude counter did not wrap");
  AST_AMPL_HIGH: assert property (
    (q.st == SNDGEN_PLAY) && !q.comb |->
      volume_pwm_out == (q.ampl_cnt <= q.c_ahigh))
    else $error("volume output disagrees with high time");
  AST_TONE_WRAP: assert property (
    (q.st == SNDGEN_PLAY) && tick && ampl_end && tone_end |=>
      q.tone_cnt == 17'h00000)
    else $error("tone counter did not wrap at twice period");
  AST_TONE_HIGH: assert property (
    (q.st == SNDGEN_PLAY) && !q.comb |->
      pitch_pwm_out == (q.tone_cnt <= {1'b0, q.c_thigh}))
    else $error("pitch output disagrees with high time");
  AST_COMBINED: assert property (
    q.comb |-> !pitch_pwm_out)
    else $error("pitch output active in combined format");
  AST_HOLD: assert property (
    (q.st == SNDGEN_PLAY) && !tick && $stable(q.st) |=>
      $stable(q.ampl_cnt) || (q.st != SNDGEN_PLAY))
    else $error("counters moved without a pwm tick");
  AST_DONE: assert property (
    s_seg_end |=> s_done)
    else $error("segment end without trigger and complete cause");
  AST_TRIG_PULSE: assert property (
    segment_done_trigger |=> !segment_done_trigger)
    else $error("trigger longer than one cycle");
  AST_COPY: assert property (
    s_seg_end ##0 q.buf_valid |=>
      q.c_aper == $past(q.b_aper) && q.st == SNDGEN_PLAY)
    else $error("buffered structure not taken over");
  AST_UNDERFLOW: assert property (
    s_seg_end ##0 !q.buf_valid |=>
      q.st == SNDGEN_IDLE && q.intr[`SNDGEN_INTR_UNDERFLOW] ##1
      !volume_pwm_out)
    else $error("underflow not raised or sound not stopped");
  AST_IF_UNDERFLOW: assert property (
    (q.st == SNDGEN_LOAD) && tick |=> q.intr[`SNDGEN_INTR_IF_UNDERFLOW])
    else $error("late sample pair not flagged");
  AST_STICKY: assert property (
    q.intr[0] && !intr_clr[0] |=> q.intr[0])
    else $error("cause lost without a clear");
  AST_IRQ: assert property (
    |(q.intr & q.mask) && $stable(q.intr) && $stable(q.mask) |-> irq)
    else $error("interrupt low with enabled cause");

endmodule : sndgen_top

// *** verilog/sndgen_defines.svh ***
`ifndef SNDGEN_DEFINES_SVH
`define SNDGEN_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SNDGEN_ADDR_CTRL 8'h00
`define SNDGEN_ADDR_IFCLK 8'h04
`define SNDGEN_ADDR_VOLUME 8'h08
`define SNDGEN_ADDR_PITCH 8'h0C
`define SNDGEN_ADDR_DURATION 8'h10
`define SNDGEN_ADDR_RAMP 8'h14
`define SNDGEN_ADDR_STATUS 8'h18
`define SNDGEN_ADDR_INTR 8'h1C
`define SNDGEN_ADDR_INTR_MASK 8'h20
`define SNDGEN_ADDR_INTR_MASKED 8'h24

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SNDGEN_CTRL_EN 0
`define SNDGEN_CTRL_COMB 1
`define SNDGEN_IF_SEL_LSB 0
`define SNDGEN_IF_DIV_LSB 8
`define SNDGEN_STAT_PLAY 0
`define SNDGEN_STAT_BUFV 1
`define SNDGEN_INTR_COMPLETE 0
`define SNDGEN_INTR_UNDERFLOW 1
`define SNDGEN_INTR_IF_UNDERFLOW 2

// ----------------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------------
`define SNDGEN_RST_FIELD 16'h0000
`define SNDGEN_RST_DIV 8'h00
`define SNDGEN_RST_SEL 3'h0
`define SNDGEN_RST_MASK 3'h0
`define SNDGEN_RESP_OKAY 2'h0
`define SNDGEN_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SNDGEN_ACLK_PERIOD_NS 4

`endif

// *** verilog/sndgen_pkg.sv ***
package sndgen_pkg;

  // core sequencing states, one-hot
  typedef enum logic [2:0] {
    SNDGEN_IDLE = 3'b001,
    SNDGEN_LOAD = 3'b010,
    SNDGEN_PLAY = 3'b100
  } sndgen_state_t;

  // clock source select: four system clocks or the master clock
  typedef enum logic [2:0] {
    SNDGEN_SRC_SYS0 = 3'h0,
    SNDGEN_SRC_SYS1 = 3'h1,
    SNDGEN_SRC_SYS2 = 3'h2,
    SNDGEN_SRC_SYS3 = 3'h3,
    SNDGEN_SRC_MCK = 3'h4
  } sndgen_src_t;

endpackage : sndgen_pkg

// *** verilog/sndgen_clkdiv.sv ***
`timescale 1ns/10ps
`include "sndgen_defines.svh"

module sndgen_clkdiv
  import sndgen_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // asynchronous clock sources
  input wire logic [3:0] system_clock_inputs,
  input wire logic master_clock_in,
  // setup
  input wire logic [2:0] sel,
  input wire logic [7:0] div,
  input wire logic gate_en,
  // results
  output logic tick,
  output logic clk_level
);

  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic prev;
    logic [7:0] cnt;
    logic tick;
    logic lvl;
  } sndgen_div_t;

  sndgen_div_t q;
  sndgen_div_t n;
  logic sel_lvl;

  // ----------------------------------------------------------------------
  // source select, edge count, gate
  // ----------------------------------------------------------------------
  always_comb begin
    n = q;
    n.sync1 = {master_clock_in, system_clock_inputs};
    n.sync2 = q.sync1;
    unique case (sel)
      SNDGEN_SRC_SYS0: sel_lvl = q.sync2[0];
      SNDGEN_SRC_SYS1: sel_lvl = q.sync2[1];
      SNDGEN_SRC_SYS2: sel_lvl = q.sync2[2];
      SNDGEN_SRC_SYS3: sel_lvl = q.sync2[3];
      default: sel_lvl = q.sync2[4];
    endcase
    n.prev = sel_lvl;
    n.lvl = sel_lvl;
    n.tick = 1'b0;
    // divider runs only while gated on, so a restart begins from zero
    if (!gate_en) begin
      n.cnt = 8'h00;
    end else if (sel_lvl && !q.prev) begin
      // lowering the divider below the running count ticks and restarts at the next source rising edge
      if (q.cnt >= div) begin
        n.cnt = 8'h00;
        n.tick = 1'b1;
      end else begin
        n.cnt = q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tick = q.tick;
  assign clk_level = q.lvl;

endmodule : sndgen_clkdiv

// *** verification/sndgen_speaker_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// pwm line meter, results in aclk cycles
// ----------------------------------------------------------------------
module sndgen_pwm_meter (
  // clock
  input wire logic aclk,
  // watched line and last complete measurements
  input wire logic line,
  output int high_len,
  output int period_len
);
  int run_h = 0;
  int run_p = 0;
  logic last = 1'b0;
  always @(posedge aclk) begin
    run_p = run_p + 1;
    run_h = run_h + 1;
    if (line === 1'b1 && last !== 1'b1) begin
      period_len <= run_p;
      run_p = 0;
      run_h = 0;
    end
    if (line !== 1'b1 && last === 1'b1) high_len <= run_h;
    last = line;
  end
endmodule : sndgen_pwm_meter

// ----------------------------------------------------------------------
// amplifier side: clock sources in, pwm lines measured
// ----------------------------------------------------------------------
module sndgen_speaker_model (
  // clock
  input wire logic aclk,
  // pwm lines from the block
  input wire logic volume_pwm_out,
  input wire logic pitch_pwm_out,
  // clock sources, 32 ns so each undivided tick spans exactly 8 aclk cycles
  output logic [3:0] system_clock_inputs,
  output logic master_clock_in,
  // measurements
  output int vol_high,
  output int vol_period,
  output int pitch_high,
  output int pitch_period
);
  initial begin
    system_clock_inputs = 4'h0;
    master_clock_in = 1'b0;
    #1;
    forever #16 system_clock_inputs = ~system_clock_inputs;
  end
  initial begin
    #3;
    forever #16 master_clock_in = ~master_clock_in;
  end
  sndgen_pwm_meter i_vol (.aclk(aclk), .line(volume_pwm_out),
    .high_len(vol_high), .period_len(vol_period));
  sndgen_pwm_meter i_pitch (.aclk(aclk), .line(pitch_pwm_out),
    .high_len(pitch_high), .period_len(pitch_period));
endmodule : sndgen_speaker_model

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
`include "sndgen_defines.svh"
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, master_clock_in, master_clock_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [3:0] system_clock_inputs;
  logic volume_pwm_out, pitch_pwm_out, segment_done_trigger, irq;
  int vol_high, vol_period, pitch_high, pitch_period;
  int err_total = 0;
  int checked = 0;
  int pitch_hi = 0;
  int mck_hi = 0;

  always #2 aclk = ~aclk;
  always @(posedge aclk) if (pitch_pwm_out === 1'b1) pitch_hi <= pitch_hi + 1;
  always @(posedge aclk) if (master_clock_out === 1'b1) mck_hi <= mck_hi + 1;

  sndgen_top i_sndgen_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .system_clock_inputs(system_clock_inputs),
    .master_clock_in(master_clock_in), .master_clock_out(master_clock_out),
    .volume_pwm_out(volume_pwm_out), .pitch_pwm_out(pitch_pwm_out),
    .segment_done_trigger(segment_done_trigger), .irq(irq));
  sndgen_speaker_model i_sndgen_speaker_model (.aclk(aclk),
    .volume_pwm_out(volume_pwm_out), .pitch_pwm_out(pitch_pwm_out),
    .system_clock_inputs(system_clock_inputs),
    .master_clock_in(master_clock_in), .vol_high(vol_high),
    .vol_period(vol_period), .pitch_high(pitch_high),
    .pitch_period(pitch_period));

  // --------------------------------------------------------------------
  // reporting
  // --------------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic fail(input string m);
    err_total++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail
  task automatic check_val(input logic [31:0] got, exp, input string m);
    checked++;
    if (got !== exp) fail(m);
  endtask : check_val
  task automatic check_int(input int got, exp, input string m);
    checked++;
    if (got != exp) fail(m);
  endtask : check_int

  // --------------------------------------------------------------------
  // bus master; readies are sampled with their pre-edge values
  // --------------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    int n;
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    fail("write timeout");
    print_verdict;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    fail("read timeout");
    print_verdict;
  endtask : axi_read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check_val(r, `SNDGEN_RESP_OKAY, "write response");
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input string m);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check_val(d, exp, m);
  endtask : rd_chk
  // loads the buffered structure and commits it
  task automatic seg(input logic [31:0] v, p, t, input logic ramp);
    wr(`SNDGEN_ADDR_VOLUME, v);
    wr(`SNDGEN_ADDR_PITCH, p);
    wr(`SNDGEN_ADDR_DURATION, t);
    wr(`SNDGEN_ADDR_RAMP, {31'h0, ramp});
    wr(`SNDGEN_ADDR_STATUS, 32'h2);
  endtask : seg
  task automatic wait_trig(output int cyc);
    for (cyc = 1; cyc < 5000; cyc++) begin
      @(posedge aclk);
      if (segment_done_trigger === 1'b1) return;
    end
    fail("trigger timeout");
    print_verdict;
  endtask : wait_trig

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic test_bus;
    logic [31:0] d;
    logic [1:0] r;
    rd_chk(`SNDGEN_ADDR_INTR_MASK, 32'h0, "mask reset");
    axi_read(8'h30, d, r);
    check_val(r, `SNDGEN_RESP_SLVERR, "unmapped read resp");
    check_val(d, 32'h0, "unmapped read data");
    axi_write(8'h30, 32'hFFFF_FFFF, r);
    check_val(r, `SNDGEN_RESP_SLVERR, "unmapped write resp");
    $display("test bus done");
  endtask : test_bus
  // amp 4 ticks high 2, tone 4 amp high 2, segment 2 tones: 256 cycles
  task automatic test_basic;
    int c;
    wr(`SNDGEN_ADDR_IFCLK, 32'h0);
    wr(`SNDGEN_ADDR_INTR_MASK, 32'h7);
    wr(`SNDGEN_ADDR_CTRL, 32'h1);
    seg(32'h0001_0003, 32'h0001_0001, 32'h0001_0000, 1'b0);
    seg(32'h0001_0003, 32'h0001_0001, 32'h0001_0000, 1'b0);
    wait_trig(c);
    wait_trig(c);
    check_int(c, 256, "segment length");
    check_int(vol_period, 32, "amp period");
    check_int(vol_high, 16, "amp high");
    check_int(pitch_period, 128, "tone period");
    check_int(pitch_high, 64, "tone high");
    repeat (3) @(posedge aclk);
    check_val(irq, 32'h1, "irq set");
    // the first start lands its load cycle on a tick: late pair flagged
    rd_chk(`SNDGEN_ADDR_INTR, 32'h7, "causes");
    rd_chk(`SNDGEN_ADDR_INTR_MASKED, 32'h7, "masked causes");
    rd_chk(`SNDGEN_ADDR_STATUS, 32'h0, "stopped");
    repeat (64) @(posedge aclk);
    check_val(volume_pwm_out, 32'h0, "sound stopped");
    wr(`SNDGEN_ADDR_INTR, 32'h7);
    rd_chk(`SNDGEN_ADDR_INTR, 32'h0, "causes cleared");
    check_val(irq, 32'h0, "irq cleared");
    $display("test basic done");
  endtask : test_basic
  // master clock, divide by 2, combined format, only complete enabled
  task automatic test_comb;
    int c;
    int p0;
    int m0;
    wr(`SNDGEN_ADDR_IFCLK, 32'h0000_0104);
    wr(`SNDGEN_ADDR_INTR_MASK, 32'h1);
    wr(`SNDGEN_ADDR_CTRL, 32'h3);
    p0 = pitch_hi;
    seg(32'h0001_0003, 32'h0001_0001, 32'h0001_0000, 1'b0);
    wait_trig(c);
    check_int(vol_high, 32, "combined high");
    check_int(pitch_hi - p0, 0, "tone line idle");
    m0 = mck_hi;
    repeat (16) @(posedge aclk);
    check_int(mck_hi - m0, 8, "master clock out");
    repeat (3) @(posedge aclk);
    check_val(irq, 32'h1, "irq complete");
    wr(`SNDGEN_ADDR_INTR, 32'h1);
    rd_chk(`SNDGEN_ADDR_INTR, 32'h2, "underflow stays");
    check_val(irq, 32'h0, "masked cause");
    wr(`SNDGEN_ADDR_INTR, 32'h7);
    $display("test comb done");
  endtask : test_comb
  // decreasing ramp: high 3 ticks then 2 ticks in the second time period
  task automatic test_ramp;
    int c;
    wr(`SNDGEN_ADDR_IFCLK, 32'h0);
    wr(`SNDGEN_ADDR_CTRL, 32'h1);
    seg(32'h0002_0003, 32'h0001_0001, 32'h0001_0000, 1'b1);
    wait_trig(c);
    check_int(vol_high, 16, "ramp high");
    wr(`SNDGEN_ADDR_INTR, 32'h7);
    $display("test ramp done");
  endtask : test_ramp

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    test_bus;
    test_basic;
    test_comb;
    test_ramp;
    print_verdict;
  end
endmodule : tb_top
